// File: src/log_min_defs.vh
// constants for the fault log and minimum telemetry block
`ifndef LOG_MIN_DEFS_VH
`define LOG_MIN_DEFS_VH
// command codes
`define CMD_LOT 8'hb0
`define CMD_COEF 8'hb1
`define CMD_PINS 8'hb2
`define CMD_SPARE_U 8'hb3
`define CMD_SPARE_P 8'hb4
`define CMD_VOUT_MIN 8'hb5
`define CMD_VIN_MIN 8'hb6
`define CMD_TEMP_MIN 8'hb7
`define CMD_LOG_SAVE 8'hb8
`define CMD_LOG_RELOAD 8'hb9
`define CMD_LOG_ERASE 8'hba
`define CMD_LOG_STATUS 8'hbb
`define CMD_LOG_READ 8'hbc
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_SAVE_ALL 8'h15
`define CMD_LOAD_ALL 8'h16
// reset values
`define VOUT_MIN_RST 16'hffff
`define L11_MIN_RST 16'h7bff
`define COEF_RST 16'hba00
`define SPARE_RST 16'h0000
// status bit positions
`define ST_NV_LOG 0
`define ST_RAM_LOCK 1
`define PIN_WP 0
`define PIN_SHARE 1
// 1.0 in the q16 fixed point used for coefficients
`define Q16_ONE 48'sh000000010000
`endif

// File: src/fault_log_min.v
// fault log control, minimum trackers, discharge checks and pin status
//
// Behaviour
// - channel turned on at or above coefficient times setpoint sets fail flag, alert low.
// - such a channel is held off until output falls below the threshold.
// - coefficient above 1.0 disables the discharge check entirely.
// - coefficient is a 16-bit short float value, 5-bit exponent, 11-bit mantissa.
// - pin status bit 1 is 1 when shared timebase pin low; bits 7:2 zero.
// - pin status bit 0 follows the write-lock pin level.
// - save-all stores spare words; load-all reloads them from nonvolatile memory.
// - scratchpad is one unpaged word plus one word per each of 8 pages.
// - output voltage minima go to 0xffff at reset and on clear-all-faults.
// - output voltage minimum frozen while undervoltage detection is disabled.
// - output voltage minimum unsupported on odd channels measuring current.
// - output voltage minimum is a 16-bit unsigned implied-exponent value.
// - input voltage minimum resets to 0x7bff, frozen while off for low input.
// - die temperature minimum tracks lowest reading, resets to 0x7bff.
// - ram log refreshed in operation; fault copies it to nonvolatile and locks.
// - log-save moves the ram log into the nonvolatile area.
// - log-reload copies nonvolatile log to ram, then freezes ram until read or erase.
// - log-erase erases the nonvolatile log and re-enables transfers.
// - nonvolatile-log bit set by save or fault transfer, cleared only by erase.
// - ram-lock bit set by reload, cleared by log read or erase.
// - nonvolatile-log bit at 1 inhibits every ram-to-nonvolatile transfer.
// - ram log refreshed after each conversion only while ram-lock is clear.
// - transfer on latch-off or save only with log enable 1 and bit 0 clear.
// - discharge failures never start a log transfer.
`timescale 1ns/1ps
`default_nettype none
`include "log_min_defs.vh"
module fault_log_min #(
    parameter CHANNELS = 8,
    parameter [7:0] LOT_CODE = 8'h5a // arbitrary value
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // command port
    input wire cmd_valid_i,
    input wire cmd_write_i,
    input wire [7:0] cmd_code_i,
    input wire [2:0] cmd_page_i,
    input wire [15:0] cmd_wdata_i,
    output reg rsp_valid_o,
    output reg rsp_err_o,
    output reg [15:0] rsp_data_o,
    // measurements
    input wire meas_valid_i,
    input wire [2:0] meas_chan_i,
    input wire [15:0] meas_vout_i,
    input wire vin_valid_i,
    input wire [15:0] vin_i,
    input wire temp_valid_i,
    input wire [15:0] temp_i,
    // channel control
    input wire [CHANNELS-1:0] uv_enable_i,
    input wire [CHANNELS-1:0] current_mode_i,
    input wire vin_low_off_i,
    input wire [CHANNELS-1:0] on_cmd_i,
    input wire [CHANNELS*16-1:0] setpoint_i,
    output reg [CHANNELS-1:0] on_allowed_o,
    output reg [CHANNELS-1:0] discharge_fail_o,
    output reg alert_n_o,
    // fault log engine
    input wire log_enable_i,
    input wire latch_off_i,
    output reg nv_store_o,
    output reg nv_load_o,
    output reg nv_erase_o,
    output reg ram_refresh_o,
    output reg [1:0] log_status_o,
    // configuration store
    input wire nv_cfg_valid_i,
    input wire [(CHANNELS+1)*16-1:0] nv_cfg_data_i,
    output reg cfg_save_o,
    output reg cfg_load_o,
    output reg [(CHANNELS+1)*16-1:0] spare_image_o,
    // pins
    input wire share_clk_i,
    input wire write_protect_i
);

// short float to q16 fixed point
function signed [47:0] l11_fix;
    input [15:0] x;
    reg signed [47:0] m;
    reg [5:0] e;
    begin
        m = {{37{x[10]}}, x[10:0]};
        e = {x[15], x[15:11]} + 6'd16;
        l11_fix = m <<< e;
    end
endfunction

reg [CHANNELS*16-1:0] coef_r;
reg [CHANNELS*16-1:0] last_vout_r;
reg [CHANNELS*16-1:0] vout_min_r;
reg [15:0] vin_min_r;
reg [15:0] temp_min_r;
reg [CHANNELS-1:0] hold_r;
reg nv_log_r;
reg ram_lock_r;
reg share_s1_r;
reg share_s2_r;
reg wp_s1_r;
reg wp_s2_r;

reg [CHANNELS-1:0] hold_nxt;
reg [CHANNELS-1:0] fail_nxt;
reg [15:0] rd_nxt;
reg err_nxt;
reg nv_log_nxt;
reg ram_lock_nxt;
reg [15:0] status_word;
reg [15:0] pin_word;

wire [CHANNELS-1:0] below;
wire [CHANNELS-1:0] check_off;
wire is_wr = cmd_valid_i & cmd_write_i;
wire is_rd = cmd_valid_i & ~cmd_write_i;
wire clear_cmd = cmd_valid_i & (cmd_code_i == `CMD_CLEAR_FAULTS);
wire save_cmd = cmd_valid_i & (cmd_code_i == `CMD_LOG_SAVE);
wire reload_cmd = cmd_valid_i & (cmd_code_i == `CMD_LOG_RELOAD);
wire erase_cmd = cmd_valid_i & (cmd_code_i == `CMD_LOG_ERASE);
wire read_log = is_rd & (cmd_code_i == `CMD_LOG_READ);
wire coef_wr = is_wr & (cmd_code_i == `CMD_COEF);
wire spare_u_wr = is_wr & (cmd_code_i == `CMD_SPARE_U);
wire spare_p_wr = is_wr & (cmd_code_i == `CMD_SPARE_P);
wire save_all_cmd = cmd_valid_i & (cmd_code_i == `CMD_SAVE_ALL);
wire load_all_cmd = cmd_valid_i & (cmd_code_i == `CMD_LOAD_ALL);
wire conv = meas_valid_i | vin_valid_i | temp_valid_i;
wire odd_cur = meas_chan_i[0] & current_mode_i[meas_chan_i];
wire page_cur = cmd_page_i[0] & current_mode_i[cmd_page_i];
// latch-off is the only fault source here; discharge fails stay out
wire xfer_req = (save_cmd | latch_off_i) & log_enable_i & ~nv_log_r;

genvar g;
generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
        wire signed [47:0] cq;
        wire signed [63:0] thr;
        wire signed [63:0] mq;
        assign cq = l11_fix(coef_r[g*16 +: 16]);
        assign thr = cq * $signed({1'b0, setpoint_i[g*16 +: 16]});
        assign mq = $signed({32'h00000000, last_vout_r[g*16 +: 16], 16'h0000});
        assign below[g] = mq < thr;
        assign check_off[g] = cq > `Q16_ONE;
    end
endgenerate

integer i;

// discharge hold and fail flags
always @* begin
    hold_nxt = hold_r;
    fail_nxt = discharge_fail_o;
    for (i = 0; i < CHANNELS; i = i + 1) begin
        if (clear_cmd) begin
            fail_nxt[i] = 1'b0;
        end
        if (below[i] | check_off[i]) begin
            hold_nxt[i] = 1'b0;
        end
        // set after clear so a same-cycle event wins
        if (on_cmd_i[i] & ~below[i] & ~check_off[i]) begin
            hold_nxt[i] = 1'b1;
            fail_nxt[i] = 1'b1;
        end
    end
end

// log status flags; sets win over clears
always @* begin
    nv_log_nxt = nv_log_r;
    ram_lock_nxt = ram_lock_r;
    if (erase_cmd) begin
        nv_log_nxt = 1'b0;
        ram_lock_nxt = 1'b0;
    end
    if (read_log) begin
        ram_lock_nxt = 1'b0;
    end
    if (xfer_req) begin
        nv_log_nxt = 1'b1;
    end
    if (reload_cmd) begin
        ram_lock_nxt = 1'b1;
    end
end

// read words built from the bit map; unused bits read zero
always @* begin
    status_word = 16'h0000;
    status_word[`ST_NV_LOG] = nv_log_r;
    status_word[`ST_RAM_LOCK] = ram_lock_r;
    pin_word = 16'h0000;
    // pin held low means the shared timebase is stopped
    pin_word[`PIN_SHARE] = ~share_s2_r;
    pin_word[`PIN_WP] = wp_s2_r;
end

// command answer
always @* begin
    rd_nxt = 16'h0000;
    err_nxt = 1'b0;
    case (cmd_code_i)
        `CMD_LOT: begin
            rd_nxt = {8'h00, LOT_CODE};
            err_nxt = cmd_write_i;
        end
        `CMD_COEF: begin
            rd_nxt = coef_r[cmd_page_i*16 +: 16];
        end
        `CMD_PINS: begin
            rd_nxt = pin_word;
            err_nxt = cmd_write_i;
        end
        `CMD_SPARE_U: begin
            rd_nxt = spare_image_o[15:0];
        end
        `CMD_SPARE_P: begin
            rd_nxt = spare_image_o[(cmd_page_i+1)*16 +: 16];
        end
        `CMD_VOUT_MIN: begin
            rd_nxt = page_cur ? 16'h0000 : vout_min_r[cmd_page_i*16 +: 16];
            err_nxt = cmd_write_i | page_cur;
        end
        `CMD_VIN_MIN: begin
            rd_nxt = vin_min_r;
            err_nxt = cmd_write_i;
        end
        `CMD_TEMP_MIN: begin
            rd_nxt = temp_min_r;
            err_nxt = cmd_write_i;
        end
        `CMD_LOG_STATUS: begin
            rd_nxt = status_word;
            err_nxt = cmd_write_i;
        end
        `CMD_LOG_READ: begin
            err_nxt = cmd_write_i;
        end
        `CMD_LOG_SAVE, `CMD_LOG_RELOAD, `CMD_LOG_ERASE,
        `CMD_CLEAR_FAULTS, `CMD_SAVE_ALL, `CMD_LOAD_ALL: begin
            rd_nxt = 16'h0000;
        end
        default: begin
            err_nxt = 1'b1;
        end
    endcase
end

// pin synchronisers; logic reads only the second stage
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        share_s1_r <= 1'b1;
        share_s2_r <= 1'b1;
    end else begin
        share_s1_r <= share_clk_i;
        share_s2_r <= share_s1_r;
    end
end

always @(posedge ref_clk_i) begin
    if (rst_i) begin
        wp_s1_r <= 1'b0;
        wp_s2_r <= 1'b0;
    end else begin
        wp_s1_r <= write_protect_i;
        wp_s2_r <= wp_s1_r;
    end
end

// command answers, one cycle after the command
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        rsp_valid_o <= 1'b0;
        rsp_err_o <= 1'b0;
        rsp_data_o <= 16'h0000;
    end else begin
        rsp_valid_o <= cmd_valid_i;
        rsp_err_o <= cmd_valid_i & err_nxt;
        rsp_data_o <= cmd_valid_i ? rd_nxt : 16'h0000;
    end
end

// discharge hold and fail state
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        hold_r <= {CHANNELS{1'b0}};
        discharge_fail_o <= {CHANNELS{1'b0}};
        on_allowed_o <= {CHANNELS{1'b1}};
        alert_n_o <= 1'b1;
    end else begin
        hold_r <= hold_nxt;
        discharge_fail_o <= fail_nxt;
        on_allowed_o <= ~hold_nxt;
        alert_n_o <= ~(|fail_nxt);
    end
end

// log engine strobes, status and configuration strobes
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        nv_log_r <= 1'b0;
        ram_lock_r <= 1'b0;
        log_status_o <= 2'b00;
        nv_store_o <= 1'b0;
        nv_load_o <= 1'b0;
        nv_erase_o <= 1'b0;
        ram_refresh_o <= 1'b0;
        cfg_save_o <= 1'b0;
        cfg_load_o <= 1'b0;
    end else begin
        nv_log_r <= nv_log_nxt;
        ram_lock_r <= ram_lock_nxt;
        log_status_o <= {ram_lock_nxt, nv_log_nxt};
        nv_store_o <= xfer_req;
        nv_load_o <= reload_cmd;
        // host is expected to see ram-lock clear first
        nv_erase_o <= erase_cmd;
        // frozen ram keeps the restored copy intact for reading
        ram_refresh_o <= conv & ~ram_lock_r;
        cfg_save_o <= save_all_cmd;
        cfg_load_o <= load_all_cmd;
    end
end

// coefficients, spares and last readings
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        coef_r <= {CHANNELS{`COEF_RST}};
        spare_image_o <= {(CHANNELS+1){`SPARE_RST}};
        last_vout_r <= {CHANNELS{16'h0000}};
    end else begin
        if (coef_wr) begin
            coef_r[cmd_page_i*16 +: 16] <= cmd_wdata_i;
        end
        if (nv_cfg_valid_i) begin
            spare_image_o <= nv_cfg_data_i;
        end else if (spare_u_wr) begin
            spare_image_o[15:0] <= cmd_wdata_i;
        end else if (spare_p_wr) begin
            spare_image_o[(cmd_page_i+1)*16 +: 16] <= cmd_wdata_i;
        end
        if (meas_valid_i) begin
            last_vout_r[meas_chan_i*16 +: 16] <= meas_vout_i;
        end
    end
end

// minimum trackers; clear-all-faults has the reset's effect
always @(posedge ref_clk_i) begin
    if (rst_i | clear_cmd) begin
        vout_min_r <= {CHANNELS{`VOUT_MIN_RST}};
        vin_min_r <= `L11_MIN_RST;
        temp_min_r <= `L11_MIN_RST;
    end else begin
        // unsigned compare suits the implied-exponent format
        if (meas_valid_i & uv_enable_i[meas_chan_i] & ~odd_cur
            & (meas_vout_i < vout_min_r[meas_chan_i*16 +: 16])) begin
            vout_min_r[meas_chan_i*16 +: 16] <= meas_vout_i;
        end
        if (vin_valid_i & ~vin_low_off_i & (l11_fix(vin_i) < l11_fix(vin_min_r))) begin
            vin_min_r <= vin_i;
        end
        if (temp_valid_i & (l11_fix(temp_i) < l11_fix(temp_min_r))) begin
            temp_min_r <= temp_i;
        end
    end
end

endmodule
`default_nettype wire

// File: tb/fault_log_min_checker.sv
// port assertions for the fault log and minimum telemetry block
`timescale 1ns/1ps
`default_nettype none
`include "log_min_defs.vh"
module fault_log_min_checker #(
    parameter CHANNELS = 8
) (
    // clock, reset, command port
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic rsp_valid_o,
    // log engine
    input wire logic log_enable_i,
    input wire logic latch_off_i,
    input wire logic nv_store_o,
    input wire logic nv_load_o,
    input wire logic nv_erase_o,
    input wire logic ram_refresh_o,
    input wire logic [1:0] log_status_o,
    // discharge
    input wire logic [CHANNELS-1:0] discharge_fail_o,
    input wire logic alert_n_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire is_save = cmd_valid_i && cmd_code_i == `CMD_LOG_SAVE;
    wire is_load = cmd_valid_i && cmd_code_i == `CMD_LOG_RELOAD;
    wire is_erase = cmd_valid_i && cmd_code_i == `CMD_LOG_ERASE;
    a_rsp_one_later: assert property (rsp_valid_o == $past(cmd_valid_i))
        else $error("response not one cycle after command");
    a_store_when_allowed: assert property (nv_store_o |->
        $past(log_enable_i && !log_status_o[0] && (latch_off_i || is_save))) else $error("unexpected log store");
    a_store_on_fault: assert property (latch_off_i && log_enable_i && !log_status_o[0]
        |=> nv_store_o && log_status_o[0]) else $error("latch-off did not store log");
    a_save_sets_flag: assert property (is_save && log_enable_i && !log_status_o[0]
        |=> nv_store_o ##0 log_status_o[0]) else $error("save did not store log");
    a_nv_flag_sticky: assert property ($fell(log_status_o[0]) |-> $past(is_erase))
        else $error("log flag cleared without erase");
    a_reload_locks: assert property (is_load |=> nv_load_o && log_status_o[1])
        else $error("reload did not lock ram");
    a_erase_clears: assert property (is_erase && !latch_off_i |=> nv_erase_o && log_status_o == 2'b00)
        else $error("erase did not clear status");
    a_refresh_unlocked: assert property (ram_refresh_o |-> !$past(log_status_o[1]))
        else $error("ram refreshed while locked");
    a_alert_follows: assert property (alert_n_o == !(|discharge_fail_o))
        else $error("alert does not follow fail flags");
    cover property (nv_store_o);
    cover property (log_status_o == 2'b11);
    cover property ($rose(|discharge_fail_o));
endmodule
`default_nettype wire

// File: tb/pm_host.sv
// command host model for the block's command port
`timescale 1ns/1ps
`default_nettype none
module pm_host (
    // clock
    input wire logic ref_clk_i,
    // command port
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic [2:0] cmd_page_o,
    output logic [15:0] cmd_wdata_o,
    input wire logic rsp_valid_i,
    input wire logic rsp_err_i,
    input wire logic [15:0] rsp_data_i
);
    int idle = 0;
    initial begin
        {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_page_o, cmd_wdata_o} = '0;
    end
    // code and data scrambled after release so stale values never look valid
    task automatic xfer(input logic wr, input logic [7:0] c, input logic [2:0] p, input logic [15:0] w,
                        output logic [15:0] d, output logic e, output logic ok);
        repeat (idle + 1) @(negedge ref_clk_i);
        {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_page_o, cmd_wdata_o} = {1'b1, wr, c, p, w};
        @(negedge ref_clk_i);
        {cmd_valid_o, cmd_code_o, cmd_wdata_o} = {1'b0, ~c, ~w};
        {ok, e, d} = {rsp_valid_i, rsp_err_i, rsp_data_i};
    endtask
endmodule
`default_nettype wire

// File: tb/test_fault_log_min.sv
// testbench for the fault log and minimum telemetry block
`timescale 1ns/1ps
`default_nettype none
`include "log_min_defs.vh"
module test_fault_log_min;
    localparam logic [7:0] LOT = 8'h3c; // arbitrary value
    logic ref_clk_i, rst_i, cmd_valid_i, cmd_write_i, rsp_valid_o, rsp_err_o, meas_valid_i, vin_valid_i;
    logic temp_valid_i, vin_low_off_i, alert_n_o, log_enable_i, latch_off_i, nv_store_o, nv_load_o;
    logic nv_erase_o, ram_refresh_o, nv_cfg_valid_i, cfg_save_o, cfg_load_o, share_clk_i, write_protect_i;
    logic [7:0] cmd_code_i, uv_enable_i, current_mode_i, on_cmd_i, on_allowed_o, discharge_fail_o;
    logic [2:0] cmd_page_i, meas_chan_i;
    logic [15:0] cmd_wdata_i, rsp_data_o, meas_vout_i, vin_i, temp_i;
    logic [127:0] setpoint_i;
    logic [1:0] log_status_o;
    logic [143:0] nv_cfg_data_i, spare_image_o;
    int num_errors = 0;
    int checks_done = 0;
    logic [15:0] d;
    logic e, ok;
    fault_log_min #(.LOT_CODE(LOT)) fault_log_min_i (.ref_clk_i, .rst_i, .cmd_valid_i, .cmd_write_i,
        .cmd_code_i, .cmd_page_i, .cmd_wdata_i, .rsp_valid_o, .rsp_err_o, .rsp_data_o, .meas_valid_i,
        .meas_chan_i, .meas_vout_i, .vin_valid_i, .vin_i, .temp_valid_i, .temp_i, .uv_enable_i,
        .current_mode_i, .vin_low_off_i, .on_cmd_i, .setpoint_i, .on_allowed_o, .discharge_fail_o,
        .alert_n_o, .log_enable_i, .latch_off_i, .nv_store_o, .nv_load_o, .nv_erase_o, .ram_refresh_o,
        .log_status_o, .nv_cfg_valid_i, .nv_cfg_data_i, .cfg_save_o, .cfg_load_o, .spare_image_o,
        .share_clk_i, .write_protect_i);
    pm_host pm_host_i (.ref_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
        .cmd_code_o(cmd_code_i), .cmd_page_o(cmd_page_i), .cmd_wdata_o(cmd_wdata_i),
        .rsp_valid_i(rsp_valid_o), .rsp_err_i(rsp_err_o), .rsp_data_i(rsp_data_o));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [2:0] p, input logic [15:0] x, input logic ee);
        pm_host_i.xfer(1'b0, c, p, 16'h0000, d, e, ok);
        chk({14'h0, ok, e}, {14'h0, 1'b1, ee});
        if (!ee) chk(d, x);
    endtask
    task automatic wr(input logic [7:0] c, input logic [2:0] p, input logic [15:0] w, input logic ee);
        pm_host_i.xfer(1'b1, c, p, w, d, e, ok);
        chk({14'h0, ok, e}, {14'h0, 1'b1, ee});
    endtask
    // one-cycle pulse on a strobe input, data scrambled afterwards
    task automatic pulse(input int k, input logic [2:0] ch, input logic [15:0] v);
        {meas_chan_i, meas_vout_i, vin_i, temp_i} = {ch, v, v, v};
        {meas_valid_i, vin_valid_i, temp_valid_i, latch_off_i, nv_cfg_valid_i} = 5'b10000 >> k;
        @(negedge ref_clk_i);
        {meas_valid_i, vin_valid_i, temp_valid_i, latch_off_i, nv_cfg_valid_i} = 5'b00000;
        {meas_vout_i, vin_i, temp_i} = {~v, ~v, ~v};
    endtask
    task automatic turn_on(input logic [2:0] exp);
        on_cmd_i[2] = 1'b1;
        @(negedge ref_clk_i);
        on_cmd_i = 8'h00;
        chk({13'h0, discharge_fail_o[2], on_allowed_o[2], alert_n_o}, {13'h0, exp});
    endtask
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test;
    end
    initial begin
        rst_i = 1'b1;
        {meas_valid_i, vin_valid_i, temp_valid_i, vin_low_off_i, latch_off_i, nv_cfg_valid_i} = '0;
        {log_enable_i, write_protect_i, share_clk_i, on_cmd_i, uv_enable_i, current_mode_i} = {3'b001, 8'h00, 8'hff, 8'h02};
        {meas_chan_i, meas_vout_i, vin_i, temp_i, setpoint_i, nv_cfg_data_i} = '0;
        setpoint_i[32+:16] = 16'h1000;
        repeat (16) @(negedge ref_clk_i);
        rst_i = 1'b0;
        rd(`CMD_VOUT_MIN, 0, 16'hffff, 0);
        rd(`CMD_VIN_MIN, 0, 16'h7bff, 0);
        rd(`CMD_TEMP_MIN, 0, 16'h7bff, 0);
        rd(`CMD_COEF, 3, `COEF_RST, 0);
        wr(`CMD_LOT, 0, 16'h0011, 1);
        rd(`CMD_LOT, 0, {8'h00, LOT}, 0);
        rd(8'hff, 0, 16'h0000, 1);
        {share_clk_i, write_protect_i} = 2'b01;
        repeat (3) @(negedge ref_clk_i);
        rd(`CMD_PINS, 0, 16'h0003, 0);
        {share_clk_i, write_protect_i} = 2'b10;
        repeat (3) @(negedge ref_clk_i);
        rd(`CMD_PINS, 0, 16'h0000, 0);
        $display("test reset_pins done");
        pulse(0, 0, 16'h1000);
        pulse(0, 0, 16'h2000);
        rd(`CMD_VOUT_MIN, 0, 16'h1000, 0);
        uv_enable_i[0] = 1'b0;
        pulse(0, 0, 16'h0500);
        rd(`CMD_VOUT_MIN, 0, 16'h1000, 0);
        uv_enable_i[0] = 1'b1;
        rd(`CMD_VOUT_MIN, 1, 16'h0000, 1);
        pulse(1, 0, 16'h0100);
        vin_low_off_i = 1'b1;
        pulse(1, 0, 16'h0080);
        vin_low_off_i = 1'b0;
        rd(`CMD_VIN_MIN, 0, 16'h0100, 0);
        pulse(2, 0, 16'h0080);
        rd(`CMD_TEMP_MIN, 0, 16'h0080, 0);
        wr(`CMD_CLEAR_FAULTS, 0, 16'h0000, 0);
        rd(`CMD_VOUT_MIN, 0, 16'hffff, 0);
        rd(`CMD_TEMP_MIN, 0, 16'h7bff, 0);
        $display("test minima done");
        pulse(3, 0, 16'h0000);
        rd(`CMD_LOG_STATUS, 0, 16'h0000, 0);
        log_enable_i = 1'b1;
        pm_host_i.idle = 3;
        pulse(3, 0, 16'h0000);
        rd(`CMD_LOG_STATUS, 0, 16'h0001, 0);
        wr(`CMD_LOG_ERASE, 0, 16'h0000, 0);
        pm_host_i.idle = 0;
        wr(`CMD_LOG_SAVE, 0, 16'h0000, 0);
        wr(`CMD_LOG_SAVE, 0, 16'h0000, 0);
        wr(`CMD_LOG_RELOAD, 0, 16'h0000, 0);
        rd(`CMD_LOG_STATUS, 0, 16'h0003, 0);
        pulse(1, 0, 16'h0400);
        pm_host_i.xfer(1'b0, `CMD_LOG_READ, 0, 16'h0000, d, e, ok);
        chk({14'h0, ok, e}, 16'h0002);
        rd(`CMD_LOG_STATUS, 0, 16'h0001, 0);
        wr(`CMD_LOG_ERASE, 0, 16'h0000, 0);
        $display("test log done");
        pulse(0, 2, 16'h1000);
        turn_on(3'b100);
        rd(`CMD_LOG_STATUS, 0, 16'h0000, 0);
        pulse(0, 2, 16'h0800);
        @(negedge ref_clk_i);
        chk({15'h0, on_allowed_o[2]}, 16'h0001);
        wr(`CMD_CLEAR_FAULTS, 0, 16'h0000, 0);
        chk({15'h0, alert_n_o}, 16'h0001);
        wr(`CMD_COEF, 2, 16'hf803, 0);
        rd(`CMD_COEF, 2, 16'hf803, 0);
        pulse(0, 2, 16'h1000);
        turn_on(3'b011);
        $display("test discharge done");
        wr(`CMD_SPARE_U, 0, 16'h1234, 0);
        wr(`CMD_SPARE_P, 7, 16'hbeef, 0);
        chk(spare_image_o[15:0], 16'h1234);
        chk(spare_image_o[128+:16], 16'hbeef);
        wr(`CMD_SAVE_ALL, 0, 16'h0000, 0);
        chk({15'h0, cfg_save_o}, 16'h0001);
        wr(`CMD_LOAD_ALL, 0, 16'h0000, 0);
        chk({15'h0, cfg_load_o}, 16'h0001);
        nv_cfg_data_i = {9{16'h00a5}};
        pulse(4, 0, 16'h0000);
        rd(`CMD_SPARE_P, 7, 16'h00a5, 0);
        $display("test spares done");
        stop_test;
    end
endmodule
bind fault_log_min fault_log_min_checker #(.CHANNELS(CHANNELS)) fault_log_min_checker_i (.ref_clk_i, .rst_i,
    .cmd_valid_i, .cmd_code_i, .rsp_valid_o, .log_enable_i, .latch_off_i, .nv_store_o, .nv_load_o,
    .nv_erase_o, .ram_refresh_o, .log_status_o, .discharge_fail_o, .alert_n_o);
`default_nettype wire
